// ==== rtl/bpbo_top.sv ====
// Bidirectional 8-bit port with external-memory-bus override and AXI4-Lite registers.
// Assumes bus control strobes come from logic on ref_clk; pins are asynchronous.
`timescale 1ns/1ns
// Function
// [RL1] Wide package has all eight pins; narrow package only pins 5 and 4.
// [RL2] Direction bit one makes the pin an input, driver off.
// [RL3] Direction bit zero drives the output latch value onto the pin.
// [RL4] Output latch readable and writable at its own address, reads latch not pin.
// [RL5] Each pin's direction is chosen on its own.
// [RL6] Every pin is a digital input after any reset.
// [RL7] External bus enabled: all pins become bus control outputs, overriding direction and data.
// [RL8] Each pin has a weak pull-up; one global bit clear disables all.
// [RL9] Pull-up is off for any pin configured as output.
// [RL10] Global pull-up enable resets to off.
// [RL11] Bus pins 0..7: latch enable, output enable, write low, write high, addr0, chip enable, lower, upper.
// [RL12] Pin-value read gives synchronised pins; write updates the output latch.
// [RL13] Unimplemented bits read zero and ignore writes.
module bpbo_top #(
  parameter bit WIDE_PACKAGE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [bpbo_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [bpbo_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [bpbo_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [bpbo_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire bpbo_pkg::bpbo_bus_ctrl_t bus_ctrl_in,
  input wire logic [bpbo_pkg::PORT_W-1:0] pin_in,
  output logic [bpbo_pkg::PORT_W-1:0] pin_out,
  output logic [bpbo_pkg::PORT_W-1:0] pin_oe,
  output logic [bpbo_pkg::PORT_W-1:0] pin_pullup_en
);
  import bpbo_pkg::*;

  // ----------------------------------------
  // Package variant
  // ----------------------------------------
  localparam logic [PORT_W-1:0] IMPL_MASK = WIDE_PACKAGE ? IMPL_MASK_WIDE : IMPL_MASK_NARROW; // RL1

  // ----------------------------------------
  // Port state
  // ----------------------------------------
  logic [PORT_W-1:0] output_latch;
  logic [PORT_W-1:0] direction;
  logic ext_bus_disable;
  logic global_pullup_enable;
  logic [PORT_W-1:0] pin_sync;

  // ----------------------------------------
  // Bus slave state
  // ----------------------------------------
  logic aw_held;
  logic w_held;
  logic [AXI_ADDR_W-1:0] aw_addr_q;
  logic [AXI_DATA_W-1:0] w_data_q;
  logic w_strb0_q;

  bpbo_sync #(
    .WIDTH(PORT_W)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(pin_in),
    .stable_out(pin_sync)
  );

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  // Commit only once both halves are held and the last response has gone
  wire wr_commit = aw_held && w_held && !s_axi_bvalid;
  wire next_aw_held = (aw_held || aw_take) && !wr_commit;
  wire next_w_held = (w_held || w_take) && !wr_commit;
  wire b_done = s_axi_bvalid && s_axi_bready;
  wire next_bvalid = wr_commit || (s_axi_bvalid && !b_done);

  wire [AXI_ADDR_W-1:0] wr_word = {aw_addr_q[AXI_ADDR_W-1:2], 2'b00};
  wire wr_pin_value = (wr_word == OFF_PIN_VALUE);
  wire wr_latch = (wr_word == OFF_OUTPUT_LATCH);
  wire wr_dir = (wr_word == OFF_DIRECTION);
  wire wr_mem_ctrl = (wr_word == OFF_MEMORY_BUS_CONTROL);
  wire wr_host_port = (wr_word == OFF_HOST_PORT_REGISTER);
  wire wr_mapped = wr_pin_value || wr_latch || wr_dir || wr_mem_ctrl || wr_host_port;
  wire wr_en = wr_commit && w_strb0_q;
  wire [PORT_W-1:0] wr_byte = w_data_q[PORT_W-1:0];
  wire [1:0] next_bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (aw_take)
      begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_data_q <= s_axi_wdata;
        w_strb0_q <= s_axi_wstrb[0];
      end
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_awready <= !next_aw_held;
      s_axi_wready <= !next_w_held;
      s_axi_bvalid <= next_bvalid;
      if (wr_commit)
      begin
        s_axi_bresp <= next_bresp;
      end
    end
  end

  // ----------------------------------------
  // Port registers
  // ----------------------------------------
  // Both the pin-value and latch addresses land in the latch
  wire latch_wr = wr_en && (wr_pin_value || wr_latch); // RL4 RL12
  wire [PORT_W-1:0] next_latch = latch_wr ? (wr_byte & IMPL_MASK) : output_latch; // RL13
  wire [PORT_W-1:0] next_dir = (wr_en && wr_dir) ? (wr_byte & IMPL_MASK) : direction; // RL5 RL13

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      output_latch <= OUTPUT_LATCH_RESET;
      direction <= DIRECTION_RESET & IMPL_MASK; // RL6
      ext_bus_disable <= EXT_BUS_DISABLE_RESET;
      global_pullup_enable <= GLOBAL_PULLUP_ENABLE_RESET; // RL10
    end
    else if (clk_en)
    begin
      output_latch <= next_latch;
      direction <= next_dir;
      if (wr_en && wr_mem_ctrl)
      begin
        ext_bus_disable <= wr_byte[EXT_BUS_DISABLE_BIT];
      end
      if (wr_en && wr_host_port)
      begin
        global_pullup_enable <= wr_byte[GLOBAL_PULLUP_ENABLE_BIT];
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire r_done = s_axi_rvalid && s_axi_rready;
  wire next_rvalid = ar_take || (s_axi_rvalid && !r_done);

  wire [AXI_ADDR_W-1:0] rd_word = {s_axi_araddr[AXI_ADDR_W-1:2], 2'b00};
  wire rd_pin_value = (rd_word == OFF_PIN_VALUE);
  wire rd_latch = (rd_word == OFF_OUTPUT_LATCH);
  wire rd_dir = (rd_word == OFF_DIRECTION);
  wire rd_mem_ctrl = (rd_word == OFF_MEMORY_BUS_CONTROL);
  wire rd_host_port = (rd_word == OFF_HOST_PORT_REGISTER);
  wire rd_mapped = rd_pin_value || rd_latch || rd_dir || rd_mem_ctrl || rd_host_port;
  wire [PORT_W-1:0] mem_ctrl_view = PORT_W'(ext_bus_disable) << EXT_BUS_DISABLE_BIT;
  wire [PORT_W-1:0] host_port_view = PORT_W'(global_pullup_enable) << GLOBAL_PULLUP_ENABLE_BIT;
  wire [PORT_W-1:0] rd_byte =
    rd_pin_value ? (pin_sync & IMPL_MASK) : // RL12 RL13
    rd_latch ? output_latch : // RL4
    rd_dir ? direction :
    rd_mem_ctrl ? mem_ctrl_view :
    rd_host_port ? host_port_view :
    '0;
  wire [AXI_DATA_W-1:0] next_rdata = {{(AXI_DATA_W-PORT_W){1'b0}}, rd_byte};
  wire [1:0] next_rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= !next_rvalid;
      if (ar_take)
      begin
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
      end
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  wire bus_mode = !ext_bus_disable;
  // Struct order places the address latch enable on pin 0
  wire [PORT_W-1:0] bus_bits = bus_ctrl_in; // RL11
  wire [PORT_W-1:0] port_drive = ~direction & IMPL_MASK; // RL2 RL3 RL5
  wire [PORT_W-1:0] next_oe = bus_mode ? IMPL_MASK : port_drive; // RL7
  wire [PORT_W-1:0] next_out = (bus_mode ? bus_bits : output_latch) & IMPL_MASK; // RL7 RL3
  // Any driven pin loses its pull-up, bus mode included
  wire [PORT_W-1:0] next_pullup = {PORT_W{global_pullup_enable}} & ~next_oe & IMPL_MASK; // RL8 RL9

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pin_out <= '0;
      pin_oe <= '0; // RL6
      pin_pullup_en <= '0; // RL10
    end
    else if (clk_en)
    begin
      pin_out <= next_out;
      pin_oe <= next_oe;
      pin_pullup_en <= next_pullup;
    end
  end

endmodule : bpbo_top

// ==== rtl/bpbo_pkg.sv ====
// Constants and carrier types for the bidirectional port with bus override.
// Assumes a 32-bit AXI4-Lite register bus and an 8-bit port.
package bpbo_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int PORT_W = 8;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_PIN_VALUE = 8'h00;
  localparam logic [7:0] OFF_OUTPUT_LATCH = 8'h04;
  localparam logic [7:0] OFF_DIRECTION = 8'h08;
  localparam logic [7:0] OFF_MEMORY_BUS_CONTROL = 8'h0C;
  localparam logic [7:0] OFF_HOST_PORT_REGISTER = 8'h10;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int EXT_BUS_DISABLE_BIT = 7;
  localparam int GLOBAL_PULLUP_ENABLE_BIT = 7;

  // ----------------------------------------
  // Implemented pins per package variant
  // ----------------------------------------
  localparam logic [7:0] IMPL_MASK_WIDE = 8'hFF;
  localparam logic [7:0] IMPL_MASK_NARROW = 8'h30;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] DIRECTION_RESET = 8'hFF;
  localparam logic [7:0] OUTPUT_LATCH_RESET = 8'h00;
  localparam logic EXT_BUS_DISABLE_RESET = 1'b1;
  localparam logic GLOBAL_PULLUP_ENABLE_RESET = 1'b0;

  // ----------------------------------------
  // AXI responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // External memory interface control strobes; pin 0 is the last field
  typedef struct packed {
    logic upper_byte_select;
    logic lower_byte_select;
    logic chip_enable;
    logic byte_addr_bit0;
    logic write_high_strobe;
    logic write_low_strobe;
    logic output_enable;
    logic addr_latch_enable;
  } bpbo_bus_ctrl_t;

endpackage : bpbo_pkg

// ==== rtl/bpbo_sync.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output follows only when stages two and three agree.
`timescale 1ns/1ns
module bpbo_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_stable;

  // Per bit: accept the new level only once two stages match
  assign next_stable = (stage2 & stage3) | (stable_out & (stage2 | stage3));

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      stable_out <= '0;
    end
    else if (clk_en)
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      stable_out <= next_stable;
    end
  end

endmodule : bpbo_sync

// ==== tb/bpbo_monitor.sv ====
// Checker on the port block's top-level ports.
// Assumes one clock domain with clk_en held high.
`timescale 1ns/1ns
module bpbo_monitor #(
  parameter bit WIDE_PACKAGE = 1'h1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [bpbo_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [bpbo_pkg::PORT_W-1:0] pin_out,
  input wire logic [bpbo_pkg::PORT_W-1:0] pin_oe,
  input wire logic [bpbo_pkg::PORT_W-1:0] pin_pullup_en
);
  import bpbo_pkg::*;
  wire logic [7:0] impl_mask = WIDE_PACKAGE ? IMPL_MASK_WIDE : IMPL_MASK_NARROW;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_reset_inputs: assert property (disable iff (1'h0)
    reset |=> pin_oe == 8'h00 && pin_pullup_en == 8'h00) else $error("Pins driven after reset");
  a_pullup_outputs: assert property ((pin_pullup_en & pin_oe) == 8'h00)
    else $error("Pull-up on a driven pin");
  a_unimpl_quiet: assert property (((pin_out | pin_oe | pin_pullup_en) & ~impl_mask) == 8'h00)
    else $error("Absent pin active");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("Write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data not held");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response not held");
  a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Second read taken");
endmodule : bpbo_monitor

bind bpbo_top bpbo_monitor #(.WIDE_PACKAGE(WIDE_PACKAGE)) i_bpbo_monitor (
  .ref_clk(ref_clk),
  .reset(reset),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .pin_out(pin_out),
  .pin_oe(pin_oe),
  .pin_pullup_en(pin_pullup_en)
);

// ==== tb/bpbo_board.sv ====
// Board model: resolves the level of each of the eight pins.
// Assumes no pull-downs; a pin nobody holds toggles every cycle.
`timescale 1ns/1ns
module bpbo_board (
  input wire logic ref_clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_lvl
);
  logic [7:0] float_pat = 8'h00;
  always @(posedge ref_clk) float_pat <= ~float_pat;
  // Floating pins never keep their last value
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drv)
    | (~pin_oe & ~ext_en & (pin_pullup_en | float_pat));
endmodule : bpbo_board

// ==== tb/tb_top.sv ====
// Bench for the port block: register bus, pin levels and bus override.
// Assumes the board model sits on the pins and clk_en stays high.
`timescale 1ns/1ns
module tb_top;
  import bpbo_pkg::*;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pin_lvl, pin_out, pin_oe, pin_pullup_en;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, data;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  bpbo_bus_ctrl_t bus_ctrl_in = '0;
  logic [7:0] ext_drv = 8'h00, ext_en = 8'h00;
  int failures = 0, samples_checked = 0;
  logic [31:0] n_rdata;
  logic [7:0] n_pin_out, n_pin_oe, n_pin_pullup_en;
  always #4 ref_clk = ~ref_clk;
  bpbo_top #(.WIDE_PACKAGE(1'h1)) i_bpbo_top (.ref_clk(ref_clk), .reset(reset), .clk_en(1'h1),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .bus_ctrl_in(bus_ctrl_in), .pin_in(pin_lvl), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en));
  bpbo_board i_bpbo_board (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .ext_drv(ext_drv), .ext_en(ext_en), .pin_lvl(pin_lvl));
  // Same bus traffic as the wide port; only pins 5 and 4 exist here
  bpbo_top #(.WIDE_PACKAGE(1'h0)) i_bpbo_top_narrow (.ref_clk(ref_clk), .reset(reset), .clk_en(1'h1),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
    .s_axi_rdata(n_rdata), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
    .bus_ctrl_in(bus_ctrl_in), .pin_in(pin_lvl), .pin_out(n_pin_out), .pin_oe(n_pin_oe),
    .pin_pullup_en(n_pin_pullup_en));
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tmo(input int n);
    if (n >= 64)
    begin
      failures++;
      end_sim();
    end
  endtask : tmo
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    int n;
    begin
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      n = 0;
      while (!(aw_ok && w_ok) && n < 64)
      begin
        @(posedge ref_clk);
        n++;
        if (s_axi_awready && !aw_ok) s_axi_awvalid <= 1'h0;
        if (s_axi_wready && !w_ok) s_axi_wvalid <= 1'h0;
        aw_ok = aw_ok | s_axi_awready;
        w_ok = w_ok | s_axi_wready;
      end
      while (!s_axi_bvalid && n < 64) @(posedge ref_clk) n++;
      tmo(n);
      s_axi_bready <= 1'h1;
      @(posedge ref_clk);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
    end
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    begin
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      n = 0;
      do @(posedge ref_clk) n++; while (!s_axi_arready && n < 64);
      s_axi_arvalid <= 1'h0;
      while (!s_axi_rvalid && n < 64) @(posedge ref_clk) n++;
      tmo(n);
      s_axi_rready <= 1'h1;
      @(posedge ref_clk);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
    end
  endtask : rd
  // ------
  // Scenarios
  // ------
  task t_reset_state;
    chk(pin_oe, 8'h00);
    chk(pin_pullup_en, 8'h00);
    rd(OFF_DIRECTION, data);
    chk(data, 32'h0000_00FF);
    rd(OFF_MEMORY_BUS_CONTROL, data);
    chk(data & 32'h0000_0080, 32'h0000_0080);
    rd(OFF_HOST_PORT_REGISTER, data);
    chk(data & 32'h0000_0080, 32'h0000_0000);
  endtask : t_reset_state
  task t_dir_latch;
    ext_drv <= 8'h5A;
    ext_en <= 8'h0F;
    wr(OFF_OUTPUT_LATCH, 32'h0000_00A5);
    wr(OFF_DIRECTION, 32'h0000_000F);
    chk(pin_oe, 8'hF0);
    chk(pin_out & pin_oe, 8'hA0);
    repeat (6) @(posedge ref_clk);
    rd(OFF_OUTPUT_LATCH, data);
    chk(data, 32'h0000_00A5);
    rd(OFF_PIN_VALUE, data);
    chk(data, 32'h0000_00AA);
  endtask : t_dir_latch
  task t_pullup;
    ext_en <= 8'h00;
    wr(OFF_HOST_PORT_REGISTER, 32'h0000_0080);
    chk(pin_pullup_en, 8'h0F);
    repeat (6) @(posedge ref_clk);
    rd(OFF_PIN_VALUE, data);
    chk(data, 32'h0000_00AF);
    wr(OFF_PIN_VALUE, 32'h0000_003C);
    rd(OFF_OUTPUT_LATCH, data);
    chk(data, 32'h0000_003C);
    chk(pin_out & pin_oe, 8'h30);
    wr(OFF_HOST_PORT_REGISTER, 32'h0000_0000);
    chk(pin_pullup_en, 8'h00);
  endtask : t_pullup
  task t_bus_override;
    int i;
    begin
      wr(OFF_MEMORY_BUS_CONTROL, 32'h0000_0000);
      for (i = 0; i < 8; i++)
      begin
        bus_ctrl_in <= bpbo_bus_ctrl_t'(8'h01 << i);
        repeat (2) @(posedge ref_clk);
        chk(pin_oe, 8'hFF);
        chk(pin_out, 8'h01 << i);
      end
      wr(OFF_MEMORY_BUS_CONTROL, 32'h0000_0080);
      chk(pin_oe, 8'hF0);
    end
  endtask : t_bus_override
  task t_unmapped;
    wr(8'h20, 32'h0000_00FF);
    chk(resp, RESP_SLVERR);
    rd(8'h20, data);
    chk(resp, RESP_SLVERR);
    chk(data, 32'h0000_0000);
    rd(OFF_DIRECTION, data);
    chk(data, 32'h0000_000F);
  endtask : t_unmapped
  task t_narrow;
    rd(OFF_OUTPUT_LATCH, data);
    chk(n_rdata, 32'h0000_0030);
    chk(n_pin_oe, 8'h30);
    chk(n_pin_out, 8'h30);
    wr(OFF_DIRECTION, 32'h0000_00FF);
    wr(OFF_HOST_PORT_REGISTER, 32'h0000_0080);
    chk(pin_pullup_en, 8'hFF);
    chk(n_pin_pullup_en, 8'h30);
    repeat (6) @(posedge ref_clk);
    rd(OFF_PIN_VALUE, data);
    chk(data, 32'h0000_00FF);
    chk(n_rdata, 32'h0000_0030);
    wr(OFF_MEMORY_BUS_CONTROL, 32'h0000_0000);
    chk(pin_pullup_en, 8'h00);
    chk(n_pin_oe, 8'h30);
    chk(n_pin_out, 8'h00);
    wr(OFF_MEMORY_BUS_CONTROL, 32'h0000_0080);
  endtask : t_narrow
  task t_mid_reset;
    wr(OFF_DIRECTION, 32'h0000_000F);
    reset <= 1'h1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'h0;
    @(posedge ref_clk);
    chk(pin_oe, 8'h00);
    chk(n_pin_oe, 8'h00);
    chk(pin_pullup_en, 8'h00);
    rd(OFF_HOST_PORT_REGISTER, data);
    chk(data, 32'h0000_0000);
    rd(OFF_DIRECTION, data);
    chk(data, 32'h0000_00FF);
    chk(n_rdata, 32'h0000_0030);
  endtask : t_mid_reset
  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    @(posedge ref_clk);
    t_reset_state();
    t_dir_latch();
    t_pullup();
    t_bus_override();
    t_unmapped();
    t_narrow();
    t_mid_reset();
    end_sim();
  end
endmodule : tb_top
